// ### verilog/sic_consts.svh
// constants for the system interface coherency and clocking block
`ifndef SIC_CONSTS_SVH
`define SIC_CONSTS_SVH

// register port word indices
`define SIC_REG_MODE 4'h0
`define SIC_REG_CTRL 4'h1
`define SIC_REG_TLB_EVEN 4'h2
`define SIC_REG_TLB_ODD 4'h3
`define SIC_REG_TLB_WRITE 4'h4
`define SIC_REG_STATUS 4'h5

// ctrl register fields
`define SIC_CTRL_VCLK_BIT 0
`define SIC_CTRL_RST 1'b0

// mode bits on the address/data bus during reset
`define SIC_MB_RATIO_MSB 18
`define SIC_MB_RATIO_LSB 15
`define SIC_MB_L2DIV_MSB 21
`define SIC_MB_L2DIV_LSB 19
`define SIC_MB_TAP_MSB 25
`define SIC_MB_TAP_LSB 22
`define SIC_MB_COHTAR_BIT 26
`define SIC_MB_EVICT_BIT 27

// mode bit power-on defaults: core divide-by-1, l2 divide-by-3
`define SIC_RATIO_RST 4'h1
`define SIC_L2DIV_RST 3'h2
`define SIC_TAP_RST 4'h0
`define SIC_COHTAR_RST 1'b0
`define SIC_EVICT_RST 1'b0

// address cycle fields
`define SIC_AD_PADDR_MSB 39
`define SIC_AD_ATTR_MSB 59
`define SIC_AD_ATTR_LSB 58
`define SIC_AD_STATE_MSB 61
`define SIC_AD_STATE_LSB 60

// translation entry low attribute field
`define SIC_TLB_ATTR_MSB 63
`define SIC_TLB_ATTR_LSB 62

// core clock ratio denominator and virtual cycle delay
`define SIC_CORE_DENOM 2'h2
`define SIC_VCYC_DELAY 4

`endif

// ### verilog/sic_pkg.sv
// types for the system interface coherency and clocking block
package sic_pkg;

  // request kinds presented in an address cycle
  typedef enum logic [2:0] {
    SIC_RQ_BLK_RD = 3'h0,
    SIC_RQ_UPGRADE = 3'h1,
    SIC_RQ_UC_RD = 3'h2,
    SIC_RQ_UC_WR = 3'h3,
    SIC_RQ_GATH_WR = 3'h4,
    SIC_RQ_ELIM = 3'h5
  } sic_req_e;

  // secondary cache block states
  typedef enum logic [1:0] {
    SIC_ST_INVALID = 2'h0,
    SIC_ST_SHARED = 2'h1,
    SIC_ST_CLEAN_OWNED = 2'h2,
    SIC_ST_DIRTY_OWNED = 2'h3
  } sic_l2st_e;

  // address cycle issue states, gray along idle -> addr -> idle
  typedef enum logic {
    SIC_IS_IDLE = 1'b0,
    SIC_IS_ADDR = 1'b1
  } sic_issue_e;

endpackage

// ### verilog/sic_vcyc_if.sv
// virtual cycle pulse carried from the strobe delay to the main logic
`timescale 1ns/100ps
`default_nettype none
interface sic_vcyc_if;
  logic vpulse;
  modport gen (output vpulse);
  modport use_side (input vpulse);
endinterface // sic_vcyc_if
`default_nettype wire

// ### verilog/sic_vcyc.sv
// virtual cycle strobe delay line
`timescale 1ns/100ps
`default_nettype none
`include "sic_consts.svh"
module sic_vcyc (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic virtual_cycle_strobe_n,
  sic_vcyc_if.gen vc
);

  logic [`SIC_VCYC_DELAY-1:0] dly_ff;
  logic [`SIC_VCYC_DELAY-1:0] nxt_dly;

  // ==========================================================
  // delay line
  // any strobe pattern is accepted, no period is assumed
  assign nxt_dly = {dly_ff[`SIC_VCYC_DELAY-2:0], ~virtual_cycle_strobe_n};
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dly_ff <= '0;
    end else begin
      dly_ff <= nxt_dly;
    end
  end

  // pulse four bus clocks after the strobe cycle
  assign vc.vpulse = dly_ff[`SIC_VCYC_DELAY-1];

  // ==========================================================
  // checks
  property p_vpulse_delay;
    @(posedge clk_sys) disable iff (!resetn)
    resetn && !virtual_cycle_strobe_n |-> ##4 vc.vpulse;
  endproperty
  a_vpulse_delay: assert property (p_vpulse_delay) else $error("virtual pulse late");

  property p_vpulse_cause;
    @(posedge clk_sys) disable iff (!resetn)
    virtual_cycle_strobe_n ##4 1'b1 |-> !vc.vpulse;
  endproperty
  a_vpulse_cause: assert property (p_vpulse_cause) else $error("pulse without strobe");

  c_vpulse_gap: cover property (@(posedge clk_sys) disable iff (!resetn)
    vc.vpulse ##1 !vc.vpulse ##1 vc.vpulse);

endmodule // sic_vcyc
`default_nettype wire

// ### verilog/sic_sysif.sv
// system interface coherency support, uncached attribute and clock setup
//
// Notes on behaviour
// - block read address cycle carries prior secondary-cache state of block
// - in slave state, another processor's coherent request marks its number busy
// - with eviction notice on, evicting shared or owned block sends eliminate
// - eliminate address cycle carries physical address and prior state
// - uncached reads and writes carry two-bit attribute in the address cycle
// - gathered uncached-accelerated block writes carry the attribute too
// - unmapped accesses take the attribute from virtual address bits 58:57
// - mapped accesses take it from the entry loaded from bits 63:62
// - a strobe makes a virtual clock pulse four bus clocks later
// - strobes may come at irregular intervals
// - system interface logic runs only on the system bus clock
// - core clock equals bus clock times ratio setting plus one over two
// - l2 clock equals bus clock times ratio plus one over divisor plus one
// - six complementary l2 clock pairs aligned by the phase tap setting
// - mode bits captured from the bus during reset while grant is asserted
// - ratio setting defaults to divide-by-1 before mode bits load
// - l2 divisor defaults to divide-by-3 before mode bits load
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "sic_consts.svh"
module sic_sysif #(
  parameter int TLB_ENTRIES = 8,
  parameter int TLB_IW = 3,
  parameter int NUM_W = 3,
  parameter int TAPS = 16
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sys_reset_n,
  input wire logic bus_grant_n,
  input wire logic [63:0] system_addr_data_bus_in,
  input wire logic virtual_cycle_strobe_n,
  output logic [63:0] system_addr_data_bus_out,
  output logic system_addr_data_bus_oe_n,
  output logic addr_cycle_valid,
  output logic [2:0] addr_cycle_kind,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_kind,
  input wire logic [39:0] req_paddr,
  input wire logic [1:0] req_prior_state,
  input wire logic req_mapped,
  input wire logic [1:0] req_va_58_57,
  input wire logic [TLB_IW-1:0] req_tlb_index,
  input wire logic req_odd_page,
  input wire logic evict_valid,
  output logic evict_ready,
  input wire logic [39:0] evict_paddr,
  input wire logic [1:0] evict_state,
  input wire logic slave_state,
  input wire logic ext_coh_seen,
  input wire logic [NUM_W-1:0] ext_req_num,
  input wire logic req_num_release,
  input wire logic [NUM_W-1:0] release_num,
  output logic [(1<<NUM_W)-1:0] req_num_busy,
  output logic busy_reuse_allowed,
  output logic [4:0] core_clk_mult,
  output logic [1:0] core_clk_denom,
  output logic [3:0] l2_clk_div,
  input wire logic [TAPS-1:0] l2_clock_taps,
  output logic [5:0] l2_sram_clock,
  output logic [5:0] l2_sram_clock_n,
  output logic vclk_pulse,
  input wire logic [3:0] reg_addr,
  input wire logic [63:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [63:0] reg_rd_data
);

  // ==========================================================
  // virtual cycle generation
  sic_vcyc_if vc_if ();

  sic_vcyc u_vcyc (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .virtual_cycle_strobe_n(virtual_cycle_strobe_n),
    .vc(vc_if.gen)
  );

  logic vclk_mode_ff;
  wire logic bus_en;
  // every bus cycle counts when emulation mode is off
  assign bus_en = !vclk_mode_ff || vc_if.vpulse;
  assign vclk_pulse = vc_if.vpulse;

  // ==========================================================
  // mode bits
  logic [3:0] ratio_ff;
  logic [2:0] l2div_ff;
  logic [3:0] tap_ff;
  logic cohtar_ff;
  logic evict_en_ff;
  wire logic cap_en;
  // only a cold or power-on reset with grant asserted reloads them
  assign cap_en = !sys_reset_n && !bus_grant_n && bus_en;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ratio_ff <= `SIC_RATIO_RST;
      l2div_ff <= `SIC_L2DIV_RST;
      tap_ff <= `SIC_TAP_RST;
      cohtar_ff <= `SIC_COHTAR_RST;
      evict_en_ff <= `SIC_EVICT_RST;
    end else if (cap_en) begin
      ratio_ff <= system_addr_data_bus_in[`SIC_MB_RATIO_MSB:`SIC_MB_RATIO_LSB];
      l2div_ff <= system_addr_data_bus_in[`SIC_MB_L2DIV_MSB:`SIC_MB_L2DIV_LSB];
      tap_ff <= system_addr_data_bus_in[`SIC_MB_TAP_MSB:`SIC_MB_TAP_LSB];
      cohtar_ff <= system_addr_data_bus_in[`SIC_MB_COHTAR_BIT];
      evict_en_ff <= system_addr_data_bus_in[`SIC_MB_EVICT_BIT];
    end
  end

  // ==========================================================
  // clock ratios for the multiplier and divider
  // the analog loop lives outside; this block only supplies the factors
  logic [4:0] core_mult_ff;
  logic [3:0] l2_div_ff;
  wire logic [4:0] nxt_core_mult;
  wire logic [3:0] nxt_l2_div;
  assign nxt_core_mult = {1'b0, ratio_ff} + 5'h01;
  assign nxt_l2_div = {1'b0, l2div_ff} + 4'h1;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      core_mult_ff <= 5'h02;
      l2_div_ff <= 4'h3;
    end else begin
      core_mult_ff <= nxt_core_mult;
      l2_div_ff <= nxt_l2_div;
    end
  end
  assign core_clk_mult = core_mult_ff;
  assign core_clk_denom = `SIC_CORE_DENOM;
  assign l2_clk_div = l2_div_ff;

  // ==========================================================
  // l2 clock pairs, one tap of the cache clock shared by all six
  wire logic l2_tap_clk;
  assign l2_tap_clk = l2_clock_taps[tap_ff[$clog2(TAPS)-1:0]];
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_l2clk
      assign l2_sram_clock[gi] = l2_tap_clk;
      assign l2_sram_clock_n[gi] = ~l2_tap_clk;
    end
  endgenerate

  // ==========================================================
  // translation entry attribute store
  logic [1:0] stage_even_ff;
  logic [1:0] stage_odd_ff;
  logic [1:0] attr_even_ff [TLB_ENTRIES];
  logic [1:0] attr_odd_ff [TLB_ENTRIES];
  wire logic wr_even;
  wire logic wr_odd;
  wire logic wr_tlb;
  wire logic wr_ctrl;
  assign wr_even = reg_wr && (reg_addr == `SIC_REG_TLB_EVEN);
  assign wr_odd = reg_wr && (reg_addr == `SIC_REG_TLB_ODD);
  assign wr_tlb = reg_wr && (reg_addr == `SIC_REG_TLB_WRITE);
  assign wr_ctrl = reg_wr && (reg_addr == `SIC_REG_CTRL);

  // staging holds the attribute field until an entry write
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage_even_ff <= 2'h0;
      stage_odd_ff <= 2'h0;
      vclk_mode_ff <= `SIC_CTRL_RST;
    end else begin
      if (wr_even) stage_even_ff <= reg_wr_data[`SIC_TLB_ATTR_MSB:`SIC_TLB_ATTR_LSB];
      if (wr_odd) stage_odd_ff <= reg_wr_data[`SIC_TLB_ATTR_MSB:`SIC_TLB_ATTR_LSB];
      if (wr_ctrl) vclk_mode_ff <= reg_wr_data[`SIC_CTRL_VCLK_BIT];
    end
  end

  generate
    for (gi = 0; gi < TLB_ENTRIES; gi++) begin : g_tlb
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          attr_even_ff[gi] <= 2'h0;
          attr_odd_ff[gi] <= 2'h0;
        end else if (wr_tlb && (reg_wr_data[TLB_IW-1:0] == TLB_IW'(gi))) begin
          attr_even_ff[gi] <= stage_even_ff;
          attr_odd_ff[gi] <= stage_odd_ff;
        end
      end
    end
  endgenerate

  // ==========================================================
  // uncached attribute source
  wire logic [1:0] tlb_attr;
  wire logic [1:0] req_attr;
  assign tlb_attr = req_odd_page ? attr_odd_ff[req_tlb_index] : attr_even_ff[req_tlb_index];
  assign req_attr = req_mapped ? tlb_attr : req_va_58_57;

  // ==========================================================
  // address cycle issue
  sic_pkg::sic_issue_e is_ff;
  sic_pkg::sic_issue_e nxt_is;
  logic [63:0] ad_ff;
  logic ad_oe_n_ff;
  logic [2:0] ad_kind_ff;
  wire logic idle;
  wire logic evict_take;
  wire logic evict_owned;
  wire logic evict_elim;
  wire logic req_take;
  wire logic kind_attr;
  wire logic kind_state;
  logic [63:0] nxt_ad;
  logic [2:0] nxt_kind;

  assign idle = (is_ff == sic_pkg::SIC_IS_IDLE);
  // evictions go first so the cache can free the line
  assign evict_ready = idle && bus_en;
  assign req_ready = idle && bus_en && !evict_valid;
  assign evict_take = evict_valid && evict_ready;
  assign req_take = req_valid && req_ready;
  assign evict_owned = (evict_state != 2'(sic_pkg::SIC_ST_INVALID));
  // with notice off an eviction is silently accepted
  assign evict_elim = evict_take && evict_en_ff && evict_owned;
  assign kind_attr = (req_kind == 3'(sic_pkg::SIC_RQ_UC_RD)) || (req_kind == 3'(sic_pkg::SIC_RQ_UC_WR))
    || (req_kind == 3'(sic_pkg::SIC_RQ_GATH_WR));
  assign kind_state = (req_kind == 3'(sic_pkg::SIC_RQ_BLK_RD));

  // compose the address cycle word
  always_comb begin
    nxt_ad = 64'h0;
    nxt_kind = 3'(sic_pkg::SIC_RQ_ELIM);
    if (evict_elim) begin
      nxt_ad[`SIC_AD_PADDR_MSB:0] = evict_paddr;
      nxt_ad[`SIC_AD_STATE_MSB:`SIC_AD_STATE_LSB] = evict_state;
    end else begin
      nxt_kind = req_kind;
      nxt_ad[`SIC_AD_PADDR_MSB:0] = req_paddr;
      if (kind_state) nxt_ad[`SIC_AD_STATE_MSB:`SIC_AD_STATE_LSB] = req_prior_state;
      if (kind_attr) nxt_ad[`SIC_AD_ATTR_MSB:`SIC_AD_ATTR_LSB] = req_attr;
    end
  end

  // one address cycle lasts one bus or virtual cycle
  always_comb begin
    nxt_is = is_ff;
    unique case (is_ff)
      sic_pkg::SIC_IS_IDLE: if (evict_elim || req_take) nxt_is = sic_pkg::SIC_IS_ADDR;
      sic_pkg::SIC_IS_ADDR: if (bus_en) nxt_is = sic_pkg::SIC_IS_IDLE;
    endcase
  end

  // outputs only move on enabled cycles
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      is_ff <= sic_pkg::SIC_IS_IDLE;
      ad_ff <= 64'h0;
      ad_oe_n_ff <= 1'b1;
      ad_kind_ff <= 3'h0;
    end else begin
      is_ff <= nxt_is;
      if (evict_elim || req_take) begin
        ad_ff <= nxt_ad;
        ad_kind_ff <= nxt_kind;
        ad_oe_n_ff <= 1'b0;
      end else if (!idle && bus_en) begin
        ad_oe_n_ff <= 1'b1;
      end
    end
  end
  assign system_addr_data_bus_out = ad_ff;
  assign system_addr_data_bus_oe_n = ad_oe_n_ff;
  assign addr_cycle_valid = !ad_oe_n_ff;
  assign addr_cycle_kind = ad_kind_ff;

  // ==========================================================
  // request number busy tracking
  logic [(1<<NUM_W)-1:0] busy_ff;
  generate
    for (gi = 0; gi < (1 << NUM_W); gi++) begin : g_busy
      wire logic set_b;
      wire logic clr_b;
      assign set_b = slave_state && ext_coh_seen && bus_en && (ext_req_num == NUM_W'(gi));
      assign clr_b = req_num_release && bus_en && (release_num == NUM_W'(gi));
      // a new claim wins over a release in the same cycle
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          busy_ff[gi] <= 1'b0;
        end else begin
          busy_ff[gi] <= set_b | (busy_ff[gi] & ~clr_b);
        end
      end
    end
  endgenerate
  assign req_num_busy = busy_ff;
  // a busy number may carry a forwarded request only with target select off
  assign busy_reuse_allowed = !cohtar_ff && busy_ff[ext_req_num];

  // ==========================================================
  // register read port
  logic [63:0] rd_ff;
  logic [63:0] rd_mux;
  always_comb begin
    rd_mux = 64'h0;
    unique case (reg_addr)
      `SIC_REG_MODE: begin
        rd_mux[`SIC_MB_RATIO_MSB:`SIC_MB_RATIO_LSB] = ratio_ff;
        rd_mux[`SIC_MB_L2DIV_MSB:`SIC_MB_L2DIV_LSB] = l2div_ff;
        rd_mux[`SIC_MB_TAP_MSB:`SIC_MB_TAP_LSB] = tap_ff;
        rd_mux[`SIC_MB_COHTAR_BIT] = cohtar_ff;
        rd_mux[`SIC_MB_EVICT_BIT] = evict_en_ff;
      end
      `SIC_REG_CTRL: rd_mux[`SIC_CTRL_VCLK_BIT] = vclk_mode_ff;
      `SIC_REG_TLB_EVEN: rd_mux[`SIC_TLB_ATTR_MSB:`SIC_TLB_ATTR_LSB] = stage_even_ff;
      `SIC_REG_TLB_ODD: rd_mux[`SIC_TLB_ATTR_MSB:`SIC_TLB_ATTR_LSB] = stage_odd_ff;
      `SIC_REG_STATUS: rd_mux[(1<<NUM_W)-1:0] = busy_ff;
      default: rd_mux = 64'h0;
    endcase
  end

  // data only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_ff <= 64'h0;
    end else begin
      rd_ff <= reg_rd ? rd_mux : 64'h0;
    end
  end
  assign reg_rd_data = rd_ff;

  // ==========================================================
  // checks
  property p_blkrd_state;
    @(posedge clk_sys) disable iff (!resetn)
    req_take && kind_state && !evict_elim |=> addr_cycle_valid
      && system_addr_data_bus_out[`SIC_AD_STATE_MSB:`SIC_AD_STATE_LSB] == $past(req_prior_state);
  endproperty
  a_blkrd_state: assert property (p_blkrd_state) else $error("block read lacks state");

  property p_busy_set;
    @(posedge clk_sys) disable iff (!resetn)
    slave_state && ext_coh_seen && bus_en |=> req_num_busy[$past(ext_req_num)];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("number not marked busy");

  property p_elim_issue;
    @(posedge clk_sys) disable iff (!resetn)
    evict_take && evict_en_ff && evict_owned |=> addr_cycle_valid
      && addr_cycle_kind == 3'(sic_pkg::SIC_RQ_ELIM);
  endproperty
  a_elim_issue: assert property (p_elim_issue) else $error("eliminate not issued");

  property p_elim_quiet;
    @(posedge clk_sys) disable iff (!resetn)
    evict_take && !evict_en_ff |=> !addr_cycle_valid;
  endproperty
  a_elim_quiet: assert property (p_elim_quiet) else $error("eliminate while disabled");

  property p_elim_addr;
    @(posedge clk_sys) disable iff (!resetn)
    evict_elim |=> system_addr_data_bus_out[`SIC_AD_PADDR_MSB:0] == $past(evict_paddr)
      && system_addr_data_bus_out[`SIC_AD_STATE_MSB:`SIC_AD_STATE_LSB] == $past(evict_state);
  endproperty
  a_elim_addr: assert property (p_elim_addr) else $error("eliminate fields wrong");

  property p_attr_unmapped;
    @(posedge clk_sys) disable iff (!resetn)
    req_take && kind_attr && !req_mapped |=>
      system_addr_data_bus_out[`SIC_AD_ATTR_MSB:`SIC_AD_ATTR_LSB] == $past(req_va_58_57);
  endproperty
  a_attr_unmapped: assert property (p_attr_unmapped) else $error("attribute source wrong");

  property p_attr_none;
    @(posedge clk_sys) disable iff (!resetn)
    req_take && !kind_attr |=> system_addr_data_bus_out[`SIC_AD_ATTR_MSB:`SIC_AD_ATTR_LSB] == 2'h0;
  endproperty
  a_attr_none: assert property (p_attr_none) else $error("attribute on wrong kind");

  property p_vclk_hold;
    @(posedge clk_sys) disable iff (!resetn)
    vclk_mode_ff && !vc_if.vpulse |=> $stable(system_addr_data_bus_oe_n)
      && $stable(system_addr_data_bus_out);
  endproperty
  a_vclk_hold: assert property (p_vclk_hold) else $error("bus moved off virtual pulse");

  property p_capture;
    @(posedge clk_sys) disable iff (!resetn)
    cap_en ##2 1'b1 |-> core_clk_mult == 5'({1'b0, $past(
      system_addr_data_bus_in[`SIC_MB_RATIO_MSB:`SIC_MB_RATIO_LSB], 2)} + 5'h01);
  endproperty
  a_capture: assert property (p_capture) else $error("core ratio not loaded");

  c_elim: cover property (@(posedge clk_sys) disable iff (!resetn) evict_elim);
  c_capture: cover property (@(posedge clk_sys) disable iff (!resetn) cap_en);
  c_reuse: cover property (@(posedge clk_sys) disable iff (!resetn) busy_reuse_allowed);

endmodule // sic_sysif
`default_nettype wire

// ### testbench/sic_agent_model.sv
// external agent model: reset pin, grant, mode bits and virtual cycle strobe
`timescale 1ns/100ps
`default_nettype none
module sic_agent_model (
  input wire logic clk_sys,
  output logic sys_reset_n,
  output logic bus_grant_n,
  output logic [63:0] system_addr_data_bus_in,
  output logic virtual_cycle_strobe_n
);
  // ==========================================
  // idle levels: strobe held asserted outside emulation
  initial begin
    sys_reset_n = 1'b1;
    bus_grant_n = 1'b1;
    system_addr_data_bus_in = 64'h0;
    virtual_cycle_strobe_n = 1'b0;
  end
  // mode word settles two cycles before grant, all under the reset pin
  task automatic load_mode(input logic [63:0] w);
    sys_reset_n <= 1'b0;
    system_addr_data_bus_in <= w;
    repeat (2) @(posedge clk_sys);
    bus_grant_n <= 1'b0;
    @(posedge clk_sys);
    bus_grant_n <= 1'b1;
    sys_reset_n <= 1'b1;
    system_addr_data_bus_in <= ~w; // released bus never shows a stale word
    @(posedge clk_sys);
  endtask
  // aperiodic strobes, one pattern bit per cycle, low bit first
  task automatic burst(input logic [31:0] pat);
    for (int i = 0; i < 32; i++) begin
      virtual_cycle_strobe_n <= pat[i];
      @(posedge clk_sys);
    end
    virtual_cycle_strobe_n <= 1'b0;
  endtask
endmodule // sic_agent_model
`default_nettype wire

// ### testbench/sysif_coherency_and_clocking_tb.sv
// self-checking bench for the system interface coherency and clocking block
`timescale 1ns/100ps
`default_nettype none
`include "sic_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module sysif_coherency_and_clocking_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic sys_reset_n, bus_grant_n, virtual_cycle_strobe_n, req_valid, req_mapped, req_odd_page;
  logic evict_valid, slave_state, ext_coh_seen, req_num_release, reg_wr, reg_rd, tap_chk;
  logic [2:0] req_kind, req_tlb_index, ext_req_num, release_num, addr_cycle_kind;
  logic [39:0] req_paddr, evict_paddr;
  logic [1:0] req_prior_state, req_va_58_57, evict_state, core_clk_denom;
  logic [15:0] l2_clock_taps;
  logic [3:0] reg_addr, l2_clk_div, hist;
  logic [63:0] reg_wr_data, reg_rd_data, system_addr_data_bus_in, system_addr_data_bus_out, er;
  logic system_addr_data_bus_oe_n, addr_cycle_valid, req_ready, evict_ready, busy_reuse_allowed;
  logic vclk_pulse, rd_seen, acv_d;
  logic [7:0] req_num_busy;
  logic [4:0] core_clk_mult;
  logic [5:0] l2_sram_clock, l2_sram_clock_n;
  logic [66:0] ea;
  logic [66:0] exp_q[$];
  logic [63:0] rd_q[$];
  integer seed = 32'hD03C0CB2;
  int num_errors = 0;
  int n_tests = 0;

  always #4 clk_sys = ~clk_sys;

  sic_sysif u_dut (.clk_sys, .resetn, .sys_reset_n, .bus_grant_n, .system_addr_data_bus_in,
    .virtual_cycle_strobe_n, .system_addr_data_bus_out, .system_addr_data_bus_oe_n,
    .addr_cycle_valid, .addr_cycle_kind, .req_valid, .req_ready, .req_kind, .req_paddr,
    .req_prior_state, .req_mapped, .req_va_58_57, .req_tlb_index, .req_odd_page,
    .evict_valid, .evict_ready, .evict_paddr, .evict_state, .slave_state, .ext_coh_seen,
    .ext_req_num, .req_num_release, .release_num, .req_num_busy, .busy_reuse_allowed,
    .core_clk_mult, .core_clk_denom, .l2_clk_div, .l2_clock_taps, .l2_sram_clock,
    .l2_sram_clock_n, .vclk_pulse, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data);
  sic_agent_model u_agent (.clk_sys, .sys_reset_n, .bus_grant_n, .system_addr_data_bus_in,
    .virtual_cycle_strobe_n);

  // ==========================================
  // expected address word: state only where it belongs, attribute likewise
  function automatic logic [63:0] mkw(input logic [2:0] k, input logic [39:0] pa,
      input logic [1:0] st, input logic [1:0] at);
    logic [63:0] w;
    w = {24'h0, pa};
    if (k == sic_pkg::SIC_RQ_BLK_RD || k == sic_pkg::SIC_RQ_ELIM) w[61:60] = st;
    if (k >= sic_pkg::SIC_RQ_UC_RD && k <= sic_pkg::SIC_RQ_GATH_WR) w[59:58] = at;
    return w;
  endfunction
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait on a combinational ready, transfer taken at the next rising edge
  task automatic hs(input logic ev);
    int i;
    i = 0;
    do begin @(negedge clk_sys); i++; end while ((ev ? evict_ready : req_ready) !== 1'b1 && i < 80);
    if (i >= 80) begin num_errors++; test_done(); end
    @(posedge clk_sys);
  endtask
  // mapped requests carry the inverse va bits so a wrong source shows
  task automatic issue(input logic [2:0] k, input logic [39:0] pa, input logic [1:0] st,
      input logic mp, input logic [1:0] at, input logic odd);
    exp_q.push_back({k, mkw(k, pa, st, at)});
    req_kind <= k;
    req_paddr <= pa;
    req_prior_state <= st;
    req_mapped <= mp;
    req_va_58_57 <= mp ? ~at : at;
    req_tlb_index <= 3'h5;
    req_odd_page <= odd;
    req_valid <= 1'b1;
    hs(1'b0);
    req_valid <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic evict(input logic [39:0] pa, input logic [1:0] st, input logic sent);
    if (sent) exp_q.push_back({sic_pkg::SIC_RQ_ELIM, mkw(3'h5, pa, st, 2'h0)});
    evict_paddr <= pa;
    evict_state <= st;
    evict_valid <= 1'b1;
    hs(1'b1);
    evict_valid <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [63:0] e);
    rd_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask

  // ==========================================
  // watcher: read data, address cycles and the virtual pulse delay
  always @(posedge clk_sys) begin
    l2_clock_taps <= 16'($random(seed));
    rd_seen <= reg_rd;
    acv_d <= addr_cycle_valid;
    hist <= resetn ? {hist[2:0], ~virtual_cycle_strobe_n} : 4'h0;
    if (resetn) `CHK("vclk_pulse", hist[3], vclk_pulse)
    if (rd_seen) begin
      er = rd_q.size() > 0 ? rd_q.pop_front() : {64{1'bx}};
      `CHK("reg_rd_data", er, reg_rd_data)
    end
    if (addr_cycle_valid === 1'b1 && acv_d !== 1'b1) begin
      ea = exp_q.size() > 0 ? exp_q.pop_front() : {67{1'bx}};
      `CHK("addr_word", ea[63:0], system_addr_data_bus_out)
      `CHK("addr_kind", ea[66:64], addr_cycle_kind)
      `CHK("bus_oe_n", 1'b0, system_addr_data_bus_oe_n)
    end
  end
  // cache clock pairs follow the chosen tap, sampled mid-cycle
  always @(negedge clk_sys) if (tap_chk) begin
    `CHK("l2_clock", {6{l2_clock_taps[5]}}, l2_sram_clock)
    `CHK("l2_clock_n", {6{~l2_clock_taps[5]}}, l2_sram_clock_n)
  end

  // ==========================================
  // main sequence
  initial begin
    {req_valid, req_mapped, req_odd_page, evict_valid, slave_state, ext_coh_seen} = 6'h00;
    {req_num_release, reg_wr, reg_rd, tap_chk} = 4'h0;
    {req_kind, req_tlb_index, ext_req_num, release_num} = 12'h000;
    {req_paddr, evict_paddr, req_prior_state, req_va_58_57, evict_state} = 86'h0;
    {reg_addr, reg_wr_data} = 68'h0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    `CHK("core_mult", 5'h02, core_clk_mult)
    `CHK("l2_div", 4'h3, l2_clk_div)
    @(posedge clk_sys);
    evict(40'h12_3456_789A, 2'h3, 1'b0);
    // ratio 7, divisor 4, tap 5, eviction notice on, target select off
    u_agent.load_mode(64'h0000_0000_0963_8000);
    @(negedge clk_sys);
    tap_chk = 1'b1;
    `CHK("core_mult", 5'h08, core_clk_mult)
    `CHK("core_denom", 2'h2, core_clk_denom)
    `CHK("l2_div", 4'h5, l2_clk_div)
    @(posedge clk_sys);
    for (int k = 0; k < 5; k++)
      issue(3'(k), 40'($random(seed)), 2'($random(seed)), 1'b0, 2'($random(seed)), 1'b0);
    wr(`SIC_REG_TLB_EVEN, 64'h8000_0000_0000_0000);
    wr(`SIC_REG_TLB_ODD, 64'h4000_0000_0000_0000);
    wr(`SIC_REG_TLB_WRITE, 64'h5);
    issue(sic_pkg::SIC_RQ_UC_WR, 40'h00_0000_1000, 2'h3, 1'b1, 2'h2, 1'b0);
    issue(sic_pkg::SIC_RQ_GATH_WR, 40'hFF_FFFF_FFC0, 2'h0, 1'b1, 2'h1, 1'b1);
    for (int s = 0; s < 4; s++) evict(40'($random(seed)), 2'(s), s != 0);
    // busy marking: only a slave-state sighting counts
    ext_req_num <= 3'h2;
    ext_coh_seen <= 1'b1;
    @(posedge clk_sys);
    slave_state <= 1'b1;
    ext_req_num <= 3'h3;
    @(posedge clk_sys);
    ext_coh_seen <= 1'b0;
    @(negedge clk_sys);
    `CHK("busy", 8'h08, req_num_busy)
    `CHK("reuse", 1'b1, busy_reuse_allowed)
    @(posedge clk_sys);
    wr(`SIC_REG_STATUS, {64{1'b1}});
    rd(`SIC_REG_STATUS, 64'h8);
    rd(`SIC_REG_MODE, 64'h0963_8000);
    rd(4'hF, 64'h0);
    req_num_release <= 1'b1;
    release_num <= 3'h3;
    @(posedge clk_sys);
    req_num_release <= 1'b0;
    @(negedge clk_sys);
    `CHK("busy", 8'h00, req_num_busy)
    `CHK("reuse", 1'b0, busy_reuse_allowed)
    // virtual clock mode: nothing issues until a strobe comes through
    @(posedge clk_sys);
    wr(`SIC_REG_CTRL, 64'h1);
    rd(`SIC_REG_CTRL, 64'h1);
    fork
      u_agent.burst(32'hFFEF_FFFF);
      begin
        repeat (10) @(negedge clk_sys);
        `CHK("req_ready", 1'b0, req_ready)
        @(posedge clk_sys);
        issue(sic_pkg::SIC_RQ_UPGRADE, 40'h55_AAAA_5500, 2'h2, 1'b0, 2'h3, 1'b0);
      end
    join
    wr(`SIC_REG_CTRL, 64'h0);
    u_agent.burst(32'($random(seed)));
    repeat (8) @(posedge clk_sys);
    `CHK("pending", 0, exp_q.size())
    test_done();
  end
endmodule // sysif_coherency_and_clocking_tb
`default_nettype wire
